// file: dv/tec_pin_model.sv
// Model of the external signal that feeds the count input pin.
// Assumes the bench calls drive just after a rising clock edge.
`timescale 1ns/1ps

module tec_pin_model (
   input wire logic ref_clk,
   output logic pin
);
   initial pin = 1'b0;

   // Holds the pin at a level for a number of cycles; it stays put between calls.
   task automatic drive(input logic lvl, input int n);
      pin <= lvl;
      repeat (n) @(posedge ref_clk);
   endtask
endmodule // tec_pin_model

// file: dv/tec_timer_bench.sv
// Self-checking bench for the timer/event counter.
// Assumes the pin model as far side and read data one cycle after the strobe.
`timescale 1ns/1ps
`include "tec_defs.svh"

module tec_timer_bench;
   import tec_pkg::*;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic rd_d1 = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [7:0] v;
   logic [7:0] r;
   logic [7:0] rdata;
   logic pin, port_a_line_3, wake_up, irq;
   logic warm_rst = 1'b0;
   logic pfd_option = 1'b1;
   int err_count = 0;
   int cmp_count = 0;
   int seed = 4;
   int wakes = 0;
   int flips = 0;
   logic [7:0] exp_q[$];
   int tol_q[$];

   // Clock of 40 ns.
   always #20 ref_clk = ~ref_clk;

   tec_timer dut (.ref_clk(ref_clk), .rstn(rstn), .warm_rst(warm_rst), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .count_input_pin(pin),
      .pfd_option(pfd_option), .port_a_line_3(port_a_line_3), .wake_up(wake_up), .irq(irq));
   tec_pin_model u_pin (.ref_clk(ref_clk), .pin(pin));

   // Compares a seen value with its expectation and counts both.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Bus cycles hold their strobe up so that back-to-back cycles never lower and raise it twice.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      rd_stb <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input int t);
      exp_q.push_back(e);
      tol_q.push_back(t);
      addr <= a;
      rd_stb <= 1'b1;
      wr_stb <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic idle(input int n);
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      repeat (n) @(posedge ref_clk);
   endtask

   // Takes the oldest expectation whenever read data stand, and counts overflow pulses.
   always @(posedge ref_clk) begin
      rd_d1 <= rd_stb;
      if (rd_d1) begin
         v = exp_q.pop_front();
         if (tol_q.pop_front() > 0 && rdata + 8'd1 >= v && rdata <= v + 8'd1) v = rdata;
         check(rdata, v);
      end
      if (wake_up === 1'b1) wakes++;
   end

   // Counts changes of the divider line once out of reset.
   always @(port_a_line_3) if (rstn) flips++;

   // Cuts a hung run short.
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      print_verdict();
   end

   // Main sequence.
   initial begin
      repeat (10) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      rd(`TEC_OFS_CTRL, 8'h08, 0);
      wr(`TEC_OFS_CTRL, 8'hFF);
      rd(`TEC_OFS_CTRL, 8'hDF, 0);
      rd(8'h20, 8'h00, 0);
      wr(`TEC_OFS_CTRL, 8'h80);
      r = $random(seed);
      wr(`TEC_OFS_COUNT, r);
      rd(`TEC_OFS_COUNT, r, 0);
      wr(`TEC_OFS_INTERRUPT_CONTROL_0, 8'h02);
      wr(`TEC_OFS_IRQ_MASK, 8'h01);
      wr(`TEC_OFS_COUNT, 8'hF0);
      wr(`TEC_OFS_CTRL, 8'h90);
      wakes = 0;
      flips = 0;
      idle(40);
      wr(`TEC_OFS_CTRL, 8'h80);
      idle(2);
      check(8'(flips), 8'(wakes));
      check(8'(wakes > 1), 8'h01);
      check(8'(irq), 8'h01);
      wr(`TEC_OFS_INTERRUPT_CONTROL_0, 8'h40);
      idle(2);
      check(8'(irq), 8'h00);
      rd(`TEC_OFS_INTERRUPT_CONTROL_0, 8'h40, 0);
      rd(`TEC_OFS_IRQ_STAT, 8'h01, 0);
      rd(`TEC_OFS_IRQ_STAT, 8'h00, 0);
      wr(`TEC_OFS_PORT_A, 8'hF7);
      wr(`TEC_OFS_CTRL, 8'h90);
      idle(40);
      check(8'(port_a_line_3), 8'h00);
      for (int p = 0; p < 8; p++) begin
         wr(`TEC_OFS_CTRL, 8'h80);
         wr(`TEC_OFS_COUNT, 8'h00);
         wr(`TEC_OFS_CTRL, 8'h90 | 8'(p));
         idle(127);
         wr(`TEC_OFS_CTRL, 8'h80);
         rd(`TEC_OFS_COUNT, 8'd128 >> p, 1);
      end
      wr(`TEC_OFS_CTRL, 8'h40);
      wr(`TEC_OFS_COUNT, 8'h00);
      wr(`TEC_OFS_CTRL, 8'h50);
      idle(2);
      repeat (5) begin
         u_pin.drive(1'b1, 4);
         u_pin.drive(1'b0, 4);
      end
      idle(4);
      rd(`TEC_OFS_COUNT, 8'h05, 0);
      wr(`TEC_OFS_CTRL, 8'h58);
      idle(2);
      u_pin.drive(1'b1, 8);
      rd(`TEC_OFS_COUNT, 8'h05, 0);
      idle(2);
      u_pin.drive(1'b0, 8);
      rd(`TEC_OFS_COUNT, 8'h06, 0);
      wr(`TEC_OFS_CTRL, 8'hC8);
      wr(`TEC_OFS_COUNT, 8'h00);
      idle(2);
      u_pin.drive(1'b1, 4);
      wr(`TEC_OFS_CTRL, 8'hD8);
      idle(10);
      rd(`TEC_OFS_COUNT, 8'h00, 0);
      idle(2);
      u_pin.drive(1'b0, 4);
      u_pin.drive(1'b1, 20);
      u_pin.drive(1'b0, 10);
      rd(`TEC_OFS_COUNT, 8'd20, 1);
      rd(`TEC_OFS_CTRL, 8'hC8, 0);
      idle(2);
      u_pin.drive(1'b1, 8);
      u_pin.drive(1'b0, 10);
      rd(`TEC_OFS_COUNT, 8'd20, 1);
      warm_rst <= 1'b1;
      wr(`TEC_OFS_CTRL, 8'h00);
      wr(`TEC_OFS_COUNT, 8'h33);
      warm_rst <= 1'b0;
      rd(`TEC_OFS_CTRL, 8'hC8, 0);
      rd(`TEC_OFS_COUNT, 8'd20, 1);
      pfd_option <= 1'b0;
      wr(`TEC_OFS_PORT_A, 8'h08);
      idle(2);
      check(8'(port_a_line_3), 8'h01);
      idle(4);
      print_verdict();
   end
endmodule // tec_timer_bench

// file: rtl/tec_defs.svh
// Offsets, field positions, reset values and counts of the timer/event counter.
// Assumes inclusion by bare name from the package or the bench.
`ifndef TEC_DEFS_SVH
`define TEC_DEFS_SVH

`define TEC_ADDR_W 8
`define TEC_OFS_COUNT 8'h0D
`define TEC_OFS_CTRL 8'h0E
`define TEC_OFS_IRQ_STAT 8'h0F
`define TEC_OFS_IRQ_MASK 8'h10
`define TEC_OFS_INTERRUPT_CONTROL_0 8'h11
`define TEC_OFS_PORT_A 8'h12
`define TEC_CTRL_RESET 8'h08
`define TEC_CTRL_WMASK 8'hDF
`define TEC_INTERRUPT_CONTROL_0_RESET 8'h00
`define TEC_PORT_A_RESET 8'hFF
`define TEC_BIT_MODE_HI 7
`define TEC_BIT_MODE_LO 6
`define TEC_BIT_COUNT_ON 4
`define TEC_BIT_EDGE_SEL 3
`define TEC_BIT_TF 6
`define TEC_BIT_ETI 1
`define TEC_BIT_PA3 3
`define TEC_ST_OVF 0
`define TEC_ST_PW_DONE 1
`define TEC_COUNT_MAX 8'hFF

`endif

// file: rtl/tec_pkg.sv
// Types shared by the timer/event counter design.
// Assumes the constants header sits on the include path.
package tec_pkg;
   `include "tec_defs.svh"

   // Operating modes held in the two upper control bits.
   typedef enum logic [1:0] {
      TEC_MODE_UNUSED,
      TEC_MODE_EVENT,
      TEC_MODE_TIMER,
      TEC_MODE_PULSE
   } tec_mode_e;

   // Pulse-width measurement progress.
   typedef enum logic [1:0] {
      TEC_PW_ARMED,
      TEC_PW_COUNT,
      TEC_PW_DONE
   } tec_pw_e;
endpackage

// file: rtl/tec_timer.sv
// Eight-bit count-up timer/event counter with prescaler, preload, interrupt and divider output.
// Assumes one 25 MHz clock, a register port with one-cycle read latency and an asynchronous pin.
//
// Functional notes
// - One 8-bit up-counter, pin or prescaled clock.
// - Write sets preload; read returns live count.
// - Control bits 7:6 select event, timer, pulse.
// - Overflow from FFH reloads and sets flag.
// - Pulse mode counts between chosen edges.
// - One measurement held until count-on set again.
// - Pulse counting starts on edges, not levels.
// - Pulse mode overflow reloads and requests interrupt.
// - Count-on enables; hardware clears after pulse.
// - Event edge: 1 falling, 0 rising.
// - Prescale divides system clock by two-power.
// - Preload write loads counter when stopped or at overflow.
// - Counter reads block the count clock.
// - Port line 3 gates divider output; overflow wakes.
// - Clearing overflow interrupt enable blocks interrupt.
// - Control bit 5 always reads zero.
// - Divider output toggles on each overflow.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps

module tec_timer
   import tec_pkg::*;
#(
   parameter int COUNT_W = 8,
   parameter int PRESCALE_W = 7
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic warm_rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rdata,
   input wire logic count_input_pin,
   input wire logic pfd_option,
   output logic port_a_line_3,
   output logic wake_up,
   output logic irq
);

   // Two-flop synchroniser and edge detect of the count input.
   // The pin is asynchronous, so the first flop feeds no logic; the edge detect uses the second and third.
   // An edge is flagged two clocks after the pin moves and counted on the third.
   // Edge select decides which of these edges counts in event and pulse modes.
   // The edge flop resets to the idle low level, so no false edge follows reset.
   // A pulse shorter than one clock may be missed; this is a known limit.
   logic pin_meta;
   logic pin_sync;
   logic pin_prev;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         pin_prev <= 1'b0;
      end else begin
         pin_meta <= count_input_pin;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end
   wire pin_rise = pin_sync & ~pin_prev;
   wire pin_fall = ~pin_sync & pin_prev;

   // Register state.
   // The count location holds two registers: writes go to the preload and reads
   // return the live counter.
   // The control register holds the mode in bits 7:6, count-on in bit 4, the edge
   // select in bit 3 and the prescale code in bits 2:0.
   // Bit 5 of control is not stored, so it always reads as zero.
   // The status register keeps overflow in bit 0 and pulse done in bit 1.
   // The mask register uses the same layout as the status register.
   // Interrupt control 0 holds the overflow flag in bit 6 and the enable in bit 1.
   // Software clears the overflow flag in interrupt control 0 by a write.
   // The port A latch feeds port line 3, which can carry the divider output.
   // Mode code 00 is unused; the counter then never counts, though a preload write while stopped still loads it.
   // A warm reset holds counter, preload and control at their values.
   logic [COUNT_W-1:0] counter;
   logic [COUNT_W-1:0] preload;
   logic [7:0] ctrl;
   logic [7:0] interrupt_control_0;
   logic [7:0] port_a;
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic [PRESCALE_W-1:0] prescale;
   logic pfd_q;
   tec_pw_e pw_state;

   // Address decode and control fields.
   wire sel_count = addr == `TEC_OFS_COUNT;
   wire sel_ctrl = addr == `TEC_OFS_CTRL;
   wire sel_stat = addr == `TEC_OFS_IRQ_STAT;
   wire sel_mask = addr == `TEC_OFS_IRQ_MASK;
   wire sel_intc = addr == `TEC_OFS_INTERRUPT_CONTROL_0;
   wire sel_pa = addr == `TEC_OFS_PORT_A;
   wire tec_mode_e mode = tec_mode_e'(ctrl[`TEC_BIT_MODE_HI:`TEC_BIT_MODE_LO]);
   wire count_on = ctrl[`TEC_BIT_COUNT_ON];
   wire edge_select = ctrl[`TEC_BIT_EDGE_SEL];
   wire [2:0] prescale_sel = ctrl[2:0];
   wire ctrl_wr = wr_stb & sel_ctrl;
   wire ctrl_on_wr = ctrl_wr & wdata[`TEC_BIT_COUNT_ON];

   // Prescaler tick: code n gives one tick every 2**n system clocks.
   // The mask is held at eight bits so that code 7 fits; only the low bits are used.
   wire [7:0] pre_mask = (8'h01 << prescale_sel) - 8'h01;
   wire int_tick = ((prescale & pre_mask[PRESCALE_W-1:0]) == pre_mask[PRESCALE_W-1:0]);

   // Pulse-width start and stop edges follow the edge-select bit.
   wire pw_start = edge_select ? pin_rise : pin_fall;
   wire pw_stop = edge_select ? pin_fall : pin_rise;
   wire ev_edge = edge_select ? pin_fall : pin_rise;

   // Count enable per mode, blocked during a counter read.
   wire block_read = rd_stb & sel_count;
   wire event_inc = (mode == TEC_MODE_EVENT) & ev_edge;
   wire timer_inc = (mode == TEC_MODE_TIMER) & int_tick;
   wire pulse_inc = (mode == TEC_MODE_PULSE) & (pw_state == TEC_PW_COUNT) & int_tick;
   wire inc = count_on & ~block_read & (event_inc | timer_inc | pulse_inc);
   wire overflow = inc & (counter == `TEC_COUNT_MAX);
   wire pw_end = (mode == TEC_MODE_PULSE) & count_on & (pw_state == TEC_PW_COUNT) & pw_stop;

   // Prescaler runs freely; it keeps running through a warm reset, unlike counter and control.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         prescale <= '0;
      end else begin
         prescale <= prescale + 1'b1;
      end
   end

   // Counter and preload. Cold reset clears them; warm reset leaves them.
   // A running counter keeps counting after a preload write until it overflows.
   // A stopped counter takes the written value at once.
   // When an overflow meets a preload write, the written value is loaded, so the
   // newest start value is never lost.
   // A read of the count location blocks the increment for that cycle only.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         counter <= '0;
         preload <= '0;
      end else if (!warm_rst) begin
         if (wr_stb & sel_count) begin
            preload <= wdata[COUNT_W-1:0];
         end
         if (overflow) begin
            preload <= preload;
            counter <= (wr_stb & sel_count) ? wdata[COUNT_W-1:0] : preload;
            if (wr_stb & sel_count) preload <= wdata[COUNT_W-1:0];
         end else if (wr_stb & sel_count & ~count_on) begin
            counter <= wdata[COUNT_W-1:0];
         end else if (inc) begin
            counter <= counter + 1'b1;
         end
      end
   end

   // Control register; bit 5 is never stored.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl <= `TEC_CTRL_RESET;
      end else if (!warm_rst) begin
         if (ctrl_wr) begin
            ctrl <= wdata & `TEC_CTRL_WMASK;
         end else if (pw_end) begin
            ctrl[`TEC_BIT_COUNT_ON] <= 1'b0;
         end
      end
   end

   // Pulse-width sequencer: armed, counting, then done until re-armed.
   // Counting begins on an edge only, so a level already present when count-on is
   // set does not start a measurement.
   // The end of a measurement clears count-on, which holds the result until
   // software sets count-on again.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pw_state <= TEC_PW_ARMED;
      end else if (ctrl_on_wr | ~count_on | (mode != TEC_MODE_PULSE)) begin
         pw_state <= TEC_PW_ARMED;
      end else begin
         unique case (pw_state)
            TEC_PW_ARMED: if (pw_start) pw_state <= TEC_PW_COUNT;
            TEC_PW_COUNT: if (pw_stop) pw_state <= TEC_PW_DONE;
            TEC_PW_DONE: pw_state <= TEC_PW_DONE;
            default: pw_state <= TEC_PW_ARMED;
         endcase
      end
   end

   // Interrupt control 0, port A latch, and divider toggle.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         interrupt_control_0 <= `TEC_INTERRUPT_CONTROL_0_RESET;
         port_a <= `TEC_PORT_A_RESET;
         pfd_q <= 1'b0;
      end else begin
         if (wr_stb & sel_intc) begin
            interrupt_control_0 <= wdata;
         end
         if (overflow) begin
            interrupt_control_0[`TEC_BIT_TF] <= 1'b1;
         end
         if (wr_stb & sel_pa) begin
            port_a <= wdata;
         end
         if (overflow) begin
            pfd_q <= ~pfd_q;
         end
      end
   end

   // Sticky status, cleared by a read; a new event wins over the clear.
   wire [1:0] stat_set = {pw_end, overflow};
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         irq_stat <= 2'b00;
         irq_mask <= 2'b00;
      end else begin
         irq_stat <= ((rd_stb & sel_stat) ? 2'b00 : irq_stat) | stat_set;
         if (wr_stb & sel_mask) irq_mask <= wdata[1:0];
      end
   end

   // Overflow interrupt only when enabled in interrupt control 0.
   wire ovf_allow = interrupt_control_0[`TEC_BIT_ETI];
   wire [1:0] gated = irq_stat & irq_mask & {1'b1, ovf_allow};
   assign irq = |gated;

   // Port line 3 carries the divider when the option is chosen and the latch is set.
   assign port_a_line_3 = pfd_option ? (port_a[`TEC_BIT_PA3] & pfd_q) : port_a[`TEC_BIT_PA3];
   assign wake_up = overflow;

   // Read multiplexer, answered in the cycle after the strobe.
   logic [7:0] next_rdata;
   always_comb begin
      next_rdata = 8'h00;
      if (sel_count) next_rdata = 8'(counter);
      else if (sel_ctrl) next_rdata = ctrl & `TEC_CTRL_WMASK;
      else if (sel_stat) next_rdata = {6'h00, irq_stat};
      else if (sel_mask) next_rdata = {6'h00, irq_mask};
      else if (sel_intc) next_rdata = interrupt_control_0;
      else if (sel_pa) next_rdata = port_a;
   end
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= 8'h00;
      end else begin
         rdata <= rd_stb ? next_rdata : 8'h00;
      end
   end

   // Checks next to the logic.
   // Each check is gated off while a write or warm reset could legally move
   // the state that it watches.
   AST_OVF_RELOAD: assert property (@(posedge ref_clk) disable iff (!rstn)
      overflow && !wr_stb && !warm_rst |=> counter == $past(preload))
      else $error("Counter did not reload on overflow.");
   AST_OVF_FLAG: assert property (@(posedge ref_clk) disable iff (!rstn)
      overflow && !warm_rst |=> interrupt_control_0[`TEC_BIT_TF])
      else $error("Overflow flag not set.");
   AST_READ_BLOCK: assert property (@(posedge ref_clk) disable iff (!rstn)
      block_read && !wr_stb |=> counter == $past(counter))
      else $error("Counter moved during a read.");
   AST_BIT5_ZERO: assert property (@(posedge ref_clk) disable iff (!rstn)
      rd_stb && sel_ctrl |=> rdata[5] == 1'b0)
      else $error("Control bit 5 read as one.");
   AST_PW_CLEAR: assert property (@(posedge ref_clk) disable iff (!rstn)
      pw_end && !ctrl_wr && !warm_rst |=> !count_on)
      else $error("Count-on not cleared after measurement.");
   sequence pw_finished;
      pw_state == TEC_PW_DONE && !ctrl_on_wr;
   endsequence
   AST_PW_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn)
      pw_finished and (!wr_stb) |=> counter == $past(counter))
      else $error("Counter changed after measurement.");
   AST_PRELOAD_LIVE: assert property (@(posedge ref_clk) disable iff (!rstn)
      wr_stb && sel_count && count_on && !overflow && !inc && !warm_rst
      |=> counter == $past(counter))
      else $error("Running counter was loaded by a preload write.");
   AST_IRQ_GATE: assert property (@(posedge ref_clk) disable iff (!rstn)
      !ovf_allow && !irq_stat[`TEC_ST_PW_DONE] |-> !irq)
      else $error("Interrupt raised while disabled.");
   AST_PFD_TOGGLE: assert property (@(posedge ref_clk) disable iff (!rstn)
      overflow |=> pfd_q != $past(pfd_q))
      else $error("Divider did not toggle.");

   // An overflow that meets a status read still leaves its status bit set.
   AST_STAT_SET_WINS: assert property (@(posedge ref_clk) disable iff (!rstn)
      overflow && rd_stb && sel_stat |=> irq_stat[`TEC_ST_OVF])
      else $error("Overflow status lost to a simultaneous read.");

   // An enabled and unmasked overflow raises the interrupt line.
   AST_IRQ_RAISE: assert property (@(posedge ref_clk) disable iff (!rstn)
      irq_stat[`TEC_ST_OVF] && irq_mask[`TEC_ST_OVF] && ovf_allow |-> irq)
      else $error("Enabled overflow did not raise the interrupt.");

   // A stopped counter takes the value of a preload write.
   AST_PRELOAD_STOPPED: assert property (@(posedge ref_clk) disable iff (!rstn)
      wr_stb && sel_count && !count_on && !warm_rst |=> counter == $past(wdata))
      else $error("Stopped counter not loaded by a preload write.");

   // A warm reset keeps both control and counter.
   AST_WARM_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn)
      warm_rst |=> ctrl == $past(ctrl) && counter == $past(counter))
      else $error("Warm reset changed control or counter.");

   // An event edge adds one to the counter.
   AST_EVENT_STEP: assert property (@(posedge ref_clk) disable iff (!rstn)
      event_inc && count_on && !block_read && counter != `TEC_COUNT_MAX && !wr_stb && !warm_rst
      |=> counter == $past(counter) + 1'b1)
      else $error("Event edge did not advance the counter.");

   // Undivided timer mode adds one on every clock.
   AST_TIMER_STEP: assert property (@(posedge ref_clk) disable iff (!rstn)
      mode == TEC_MODE_TIMER && count_on && prescale_sel == 3'b000 && !block_read
      && counter != `TEC_COUNT_MAX && !wr_stb && !warm_rst
      |=> counter == $past(counter) + 1'b1)
      else $error("Undivided timer did not count every clock.");

   // A finished measurement stops counting and then re-arms the sequencer.
   sequence pw_stop_hit;
      pw_end && !ctrl_wr && !warm_rst;
   endsequence
   sequence pw_rearm_after;
      !count_on ##1 pw_state == TEC_PW_ARMED;
   endsequence
   AST_PW_REARM: assert property (@(posedge ref_clk) disable iff (!rstn)
      pw_stop_hit |=> pw_rearm_after)
      else $error("Sequencer did not settle after a measurement.");

endmodule // tec_timer
